// >>> core/pio_defines.vh
`ifndef PIO_DEFINES_VH
`define PIO_DEFINES_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define PIO_OFS_LATCH    8'h00
`define PIO_OFS_LEVEL    8'h04
`define PIO_OFS_DIR      8'h08
`define PIO_OFS_MUX_DIR  8'h0C
`define PIO_OFS_ODR      8'h10
`define PIO_OFS_FUNC     8'h14

// ----------------------------------------------------------------
// reset values and field positions
// ----------------------------------------------------------------
`define PIO_LATCH_RST    8'h00
`define PIO_DIR_RST      8'h00
`define PIO_MDIR_RST     3'h0
`define PIO_ODR_RST      3'h0
`define PIO_FUNC_RST     6'h00
`define PIO_F_TWOWIRE    0
`define PIO_F_TX         1
`define PIO_F_RX         2
`define PIO_F_CKO        3
`define PIO_F_CKI        4
`define PIO_F_SYNC       5
`define PIO_RESP_OKAY    2'b00
`define PIO_RESP_SLVERR  2'b10

`endif

// >>> core/pio_port.v
// --------------------------------------------------------------
// Overview of operation
// --------------------------------------------------------------
`timescale 1ns/100ps
`include "pio_defines.vh"

module pio_port (
	// clock and reset
	input  wire        CORE_CLK,
	input  wire        RESETN,
	// axi4-lite write address
	input  wire [7:0]  S_AWADDR,
	input  wire        S_AWVALID,
	output reg         S_AWREADY,
	// axi4-lite write data
	input  wire [31:0] S_WDATA,
	input  wire [3:0]  S_WSTRB,
	input  wire        S_WVALID,
	output reg         S_WREADY,
	// axi4-lite write response
	output reg  [1:0]  S_BRESP,
	output reg         S_BVALID,
	input  wire        S_BREADY,
	// axi4-lite read
	input  wire [7:0]  S_ARADDR,
	input  wire        S_ARVALID,
	output reg         S_ARREADY,
	output reg  [31:0] S_RDATA,
	output reg  [1:0]  S_RRESP,
	output reg         S_RVALID,
	input  wire        S_RREADY,
	// eight-bit port pins
	input  wire [7:0]  PORT_IN,
	output reg  [7:0]  PORT_OUT,
	output reg  [7:0]  PORT_OE,
	// mux pins: bit0 pin a, bit1 pin b, bit2 pin c
	input  wire [2:0]  MUX_IN,
	output reg  [2:0]  MUX_OUT,
	output reg  [2:0]  MUX_OE,
	// peripheral side of the mux pins
	input  wire        UART1_TX_PIN,
	input  wire        TWOWIRE_CLOCK_PIN_OUT,
	input  wire        TWOWIRE_DATA_PIN_OUT,
	input  wire        UART0_CLOCK_PIN_OUT,
	output reg         TWOWIRE_CLOCK_PIN_IN,
	output reg         TWOWIRE_DATA_PIN_IN,
	output reg         UART0_CLOCK_PIN_IN,
	output reg         UART0_RX_PIN,
	output reg         EXT_INTERRUPT_PIN,
	output reg  [2:0]  MUX_LEVEL
);

	// ----------------------------------------------------------------
	// register state
	// ----------------------------------------------------------------
	reg [7:0]  port_output_latch_r;
	reg [7:0]  port_direction_bits_r;
	reg [2:0]  mux_dir_r;      // pin_c, pin_b, pin_a direction
	reg [2:0]  mux_odr_r;      // pin_c, pin_b, pin_a open drain
	reg [5:0]  func_r;         // peripheral enables
	reg [7:0]  aw_addr_r;
	reg        aw_have_r;
	reg [31:0] w_data_r;
	reg [3:0]  w_strb_r;
	reg        w_have_r;

	wire twowire_on         = func_r[`PIO_F_TWOWIRE];
	wire tx_on              = func_r[`PIO_F_TX];
	wire rx_on              = func_r[`PIO_F_RX];
	wire serial_clk_out_sel = func_r[`PIO_F_CKO];
	wire serial_clk_in_sel  = func_r[`PIO_F_CKI];
	wire sync_mode          = func_r[`PIO_F_SYNC];
	wire pin_a_direction    = mux_dir_r[0];
	wire pin_b_direction    = mux_dir_r[1];
	wire pin_c_direction    = mux_dir_r[2];

	// merge a byte lane under its strobe
	function [7:0] lane;
		input [7:0] old;
		input [7:0] nw;
		input       en;
		begin
			lane = en ? nw : old;
		end
	endfunction

	// drive with optional open drain: high becomes released
	function [1:0] odrive;      // {oe, out}
		input en;
		input val;
		input od;
		begin
			odrive = !en ? 2'b00 : (od ? {~val, 1'b0} : {1'b1, val});
		end
	endfunction

	// pin-state view: latch where output, live pin elsewhere
	wire [7:0] port_pin_level = (port_direction_bits_r & port_output_latch_r) |
		(~port_direction_bits_r & PORT_IN);

	// ----------------------------------------------------------------
	// axi4-lite write channel: address and data in either order
	// ----------------------------------------------------------------
	wire wr_go = aw_have_r && w_have_r && !S_BVALID;

	always @(posedge CORE_CLK) begin
		if (!RESETN) begin
			S_AWREADY             <= 1'b0;
			S_WREADY              <= 1'b0;
			S_BVALID              <= 1'b0;
			S_BRESP               <= `PIO_RESP_OKAY;
			aw_have_r             <= 1'b0;
			w_have_r              <= 1'b0;
			aw_addr_r             <= 8'h00;
			w_data_r              <= 32'h0000_0000;
			w_strb_r              <= 4'h0;
			port_output_latch_r   <= `PIO_LATCH_RST;
			port_direction_bits_r <= `PIO_DIR_RST;
			mux_dir_r             <= `PIO_MDIR_RST;
			mux_odr_r             <= `PIO_ODR_RST;
			func_r                <= `PIO_FUNC_RST;
		end else begin
			S_AWREADY <= !aw_have_r && !S_AWREADY && S_AWVALID;
			S_WREADY  <= !w_have_r && !S_WREADY && S_WVALID;
			if (S_AWVALID && S_AWREADY) begin
				aw_have_r <= 1'b1;
				aw_addr_r <= S_AWADDR;
			end
			if (S_WVALID && S_WREADY) begin
				w_have_r <= 1'b1;
				w_data_r <= S_WDATA;
				w_strb_r <= S_WSTRB;
			end
			if (S_BVALID && S_BREADY)
				S_BVALID <= 1'b0;
			if (wr_go) begin
				aw_have_r <= 1'b0;
				w_have_r  <= 1'b0;
				S_BVALID  <= 1'b1;
				S_BRESP   <= `PIO_RESP_OKAY;
				case (aw_addr_r)
				`PIO_OFS_LATCH:
					port_output_latch_r <= lane(port_output_latch_r, w_data_r[7:0],
						w_strb_r[0]);
				`PIO_OFS_LEVEL: ;
				`PIO_OFS_DIR:
					port_direction_bits_r <= lane(port_direction_bits_r, w_data_r[7:0],
						w_strb_r[0]);
				`PIO_OFS_MUX_DIR:
					if (w_strb_r[0])
						mux_dir_r <= w_data_r[2:0];
				`PIO_OFS_ODR:
					if (w_strb_r[0])
						mux_odr_r <= w_data_r[2:0];
				`PIO_OFS_FUNC:
					if (w_strb_r[0])
						func_r <= w_data_r[5:0];
				default:
					S_BRESP <= `PIO_RESP_SLVERR;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// axi4-lite read channel
	// ----------------------------------------------------------------
	always @(posedge CORE_CLK) begin
		if (!RESETN) begin
			S_ARREADY <= 1'b0;
			S_RVALID  <= 1'b0;
			S_RDATA   <= 32'h0000_0000;
			S_RRESP   <= `PIO_RESP_OKAY;
		end else begin
			S_ARREADY <= !S_ARREADY && !S_RVALID && S_ARVALID;
			if (S_RVALID && S_RREADY)
				S_RVALID <= 1'b0;
			if (S_ARVALID && S_ARREADY) begin
				S_RVALID <= 1'b1;
				S_RRESP  <= `PIO_RESP_OKAY;
				case (S_ARADDR)
				`PIO_OFS_LATCH:   S_RDATA <= {24'h00_0000, port_output_latch_r};
				`PIO_OFS_LEVEL:   S_RDATA <= {24'h00_0000, port_pin_level};
				`PIO_OFS_DIR:     S_RDATA <= {24'h00_0000, port_direction_bits_r};
				`PIO_OFS_MUX_DIR: S_RDATA <= {29'h000_0000, mux_dir_r};
				`PIO_OFS_ODR:     S_RDATA <= {29'h000_0000, mux_odr_r};
				`PIO_OFS_FUNC:    S_RDATA <= {26'h00_0000, func_r};
				default: begin
					S_RDATA <= 32'h0000_0000;
					S_RRESP <= `PIO_RESP_SLVERR;
				end
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// pin function multiplexing
	// ----------------------------------------------------------------
	reg [1:0] a_drv;
	reg [1:0] b_drv;
	reg [1:0] c_drv;

	always @* begin
		// pin a: two-wire clock is always open drain by nature of the bus
		if (twowire_on)
			a_drv = odrive(1'b1, TWOWIRE_CLOCK_PIN_OUT, 1'b1);
		else if (tx_on)
			a_drv = odrive(1'b1, UART1_TX_PIN, mux_odr_r[0]);
		else
			a_drv = odrive(pin_a_direction, port_output_latch_r[3], mux_odr_r[0]);
		// pin b: priority chain; interrupt input watches it regardless
		if (twowire_on)
			b_drv = odrive(1'b1, TWOWIRE_DATA_PIN_OUT, 1'b1);
		else if (serial_clk_in_sel)
			b_drv = 2'b00;
		else if (sync_mode || serial_clk_out_sel)
			b_drv = odrive(1'b1, UART0_CLOCK_PIN_OUT, mux_odr_r[1]);
		else
			b_drv = odrive(pin_b_direction, port_output_latch_r[2], mux_odr_r[1]);
		// pin c: receive input beats the direction bit
		if (rx_on)
			c_drv = 2'b00;
		else
			c_drv = odrive(pin_c_direction, port_output_latch_r[1], mux_odr_r[2]);
	end

	// registered pin drives so every output comes from a flip-flop;
	// costs one cycle of latency between register write and pin
	always @(posedge CORE_CLK) begin
		if (!RESETN) begin
			PORT_OUT             <= 8'h00;
			PORT_OE              <= 8'h00;
			MUX_OUT              <= 3'h0;
			MUX_OE               <= 3'h0;
			TWOWIRE_CLOCK_PIN_IN <= 1'b1;
			TWOWIRE_DATA_PIN_IN  <= 1'b1;
			UART0_CLOCK_PIN_IN   <= 1'b1;
			UART0_RX_PIN         <= 1'b1;
			EXT_INTERRUPT_PIN    <= 1'b1;
			MUX_LEVEL            <= 3'h0;
		end else begin
			PORT_OUT             <= port_output_latch_r;
			PORT_OE              <= port_direction_bits_r;
			MUX_OUT              <= {c_drv[0], b_drv[0], a_drv[0]};
			MUX_OE               <= {c_drv[1], b_drv[1], a_drv[1]};
			TWOWIRE_CLOCK_PIN_IN <= twowire_on ? MUX_IN[0] : 1'b1;
			TWOWIRE_DATA_PIN_IN  <= twowire_on ? MUX_IN[1] : 1'b1;
			UART0_CLOCK_PIN_IN   <= (!twowire_on && serial_clk_in_sel) ? MUX_IN[1] : 1'b1;
			UART0_RX_PIN         <= rx_on ? MUX_IN[2] : 1'b1;
			EXT_INTERRUPT_PIN    <= MUX_IN[1];
			MUX_LEVEL            <= MUX_IN;
		end
	end

endmodule

// >>> tb/pio_board.sv
`timescale 1ns/100ps
module pio_board (
	// chip side of the pins
	input  logic [7:0] port_out, port_oe,
	input  logic [2:0] mux_out, mux_oe,
	// what the board applies where the chip lets go
	input  logic [7:0] drv_val,
	input  logic [2:0] mux_val, mux_drv,
	// resolved pin levels
	output logic [7:0] port_lvl,
	output logic [2:0] mux_lvl
);
	// ----------------------------------------------------------------
	// pin resolution
	// ----------------------------------------------------------------
	// chip wins where it drives; an idle mux line falls to its pull-up,
	// so an open-drain high is only seen if nobody else pulls low
	assign port_lvl = (port_oe & port_out) | (~port_oe & drv_val);
	assign mux_lvl  = (mux_oe & mux_out) | (~mux_oe & (~mux_drv | mux_val));
endmodule

// >>> tb/pio_port_properties.sv
`timescale 1ns/100ps
module pio_chk (
	// clock, reset and handshakes
	input logic        CORE_CLK, RESETN, S_AWVALID, S_AWREADY, S_WVALID, S_WREADY,
	input logic        S_BVALID, S_ARVALID, S_ARREADY, S_RVALID, EXT_INTERRUPT_PIN,
	input logic [1:0]  S_RRESP,
	input logic [31:0] S_RDATA,
	// pins
	input logic [7:0]  PORT_OUT, PORT_OE,
	input logic [2:0]  MUX_IN, MUX_OE, MUX_LEVEL
);
	// ----------------------------------------------------------------
	// bus and pin checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RESETN);
	// handshakes answer within the walk of the bus
	aw_take_a: assert property ($rose(S_AWVALID) |=> S_AWREADY)
		else $error("write address not taken");
	wr_answer_a: assert property (S_WVALID && S_WREADY |-> ##[1:3] S_BVALID)
		else $error("write answer late");
	ar_take_a: assert property ($rose(S_ARVALID) |=> S_ARREADY)
		else $error("read address not taken");
	rd_answer_a: assert property (S_ARVALID && S_ARREADY |=> S_RVALID)
		else $error("read answer late");
	bad_read_a: assert property (S_RVALID && S_RRESP == 2'b10 |-> S_RDATA == 0)
		else $error("refused read carries data");
	// latch and direction only move right after a write answer
	latch_hold_a: assert property ($past(RESETN) && $changed(PORT_OUT) |->
		S_BVALID || $past(S_BVALID) || $past(S_BVALID, 2)) else $error("latch moved");
	dir_hold_a: assert property ($past(RESETN) && $changed(PORT_OE) |->
		S_BVALID || $past(S_BVALID) || $past(S_BVALID, 2)) else $error("direction moved");
	// interrupt input watches pin b whatever its function
	irq_follow_a: assert property ($past(RESETN) |-> EXT_INTERRUPT_PIN == $past(MUX_IN[1]))
		else $error("interrupt input lost pin b");
	level_follow_a: assert property ($past(RESETN) |-> MUX_LEVEL == $past(MUX_IN))
		else $error("mux level stale");
	reset_clear_a: assert property (disable iff (1'b0)
		!RESETN |=> PORT_OUT == 0 && PORT_OE == 0 && MUX_OE == 0) else $error("reset left drive");
endmodule
bind pio_port pio_chk chk (.*);

// >>> tb/pio_port_tb.sv
`timescale 1ns/100ps
module pio_port_tb;
	// ----------------------------------------------------------------
	// ports, board and counters
	// ----------------------------------------------------------------
	logic        CORE_CLK, RESETN, S_AWVALID, S_AWREADY, S_WVALID, S_WREADY, S_BVALID;
	logic        S_BREADY, S_ARVALID, S_ARREADY, S_RVALID, S_RREADY, UART1_TX_PIN;
	logic        TWOWIRE_CLOCK_PIN_OUT, TWOWIRE_DATA_PIN_OUT, UART0_CLOCK_PIN_OUT;
	logic        TWOWIRE_CLOCK_PIN_IN, TWOWIRE_DATA_PIN_IN, UART0_CLOCK_PIN_IN;
	logic        UART0_RX_PIN, EXT_INTERRUPT_PIN;
	logic [7:0]  S_AWADDR, S_ARADDR, PORT_IN, PORT_OUT, PORT_OE, drv_val;
	logic [31:0] S_WDATA, S_RDATA;
	logic [3:0]  S_WSTRB;
	logic [1:0]  S_BRESP, S_RRESP;
	logic [2:0]  MUX_IN, MUX_OUT, MUX_OE, MUX_LEVEL;
	int          err_count = 0, total_checks = 0, cyc = 0;

	pio_port dut (.*);
	// board holds idle mux lines low so selected inputs read 0
	pio_board board (.port_out(PORT_OUT), .port_oe(PORT_OE), .mux_out(MUX_OUT), .mux_oe(MUX_OE),
		.drv_val(drv_val), .mux_val(3'h0), .mux_drv(3'h7), .port_lvl(PORT_IN), .mux_lvl(MUX_IN));

	// clock and hang guard
	initial begin
		CORE_CLK = 1'b0;
		forever #2.5 CORE_CLK = ~CORE_CLK;
	end
	always @(posedge CORE_CLK) begin
		cyc++;
		if (cyc == 3000) begin
			err_count++;
			results;
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// bus cycles: request held until its own ready, answer taken at its edge
	// no local limit: only the cycle ceiling above ends a wait, and counts it
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		S_AWADDR <= a;
		S_WDATA <= d;
		S_AWVALID <= 1'b1;
		S_WVALID <= 1'b1;
		do begin
			@(posedge CORE_CLK);
			if (S_AWREADY) S_AWVALID <= 1'b0;
			if (S_WREADY) S_WVALID <= 1'b0;
		end while (!S_BVALID);
		chk(32'(S_BRESP), 32'(er));
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		S_ARADDR <= a;
		S_ARVALID <= 1'b1;
		do begin
			@(posedge CORE_CLK);
			if (S_ARREADY) S_ARVALID <= 1'b0;
		end while (!S_RVALID);
		chk(S_RDATA, ed);
		chk(32'(S_RRESP), 32'(er));
	endtask
	task automatic hold_reset;
		RESETN <= 1'b0;
		repeat (10) @(posedge CORE_CLK);
		RESETN <= 1'b1;
	endtask
	task automatic t_reset;
		rd(8'h04, 32'(drv_val), 2'b00);
		rd(8'h00, 32'h0, 2'b00);
		rd(8'h08, 32'h0, 2'b00);
		rd(8'h0C, 32'h0, 2'b00);
		chk(32'({PORT_OE, 5'h0, MUX_OE}), 32'h0);
		$display("test reset_values done");
	endtask
	task automatic t_level;
		drv_val <= 8'h3C;
		wr(8'h08, 32'h0000_00F0, 2'b00);
		wr(8'h00, 32'h0000_00A5, 2'b00);
		rd(8'h04, 32'h0000_00AC, 2'b00);
		wr(8'h04, 32'h0000_00FF, 2'b00);
		rd(8'h04, 32'h0000_00AC, 2'b00);
		rd(8'h00, 32'h0000_00A5, 2'b00);
		wr(8'h18, 32'h0000_00FF, 2'b10);
		rd(8'h18, 32'h0, 2'b10);
		chk(32'({PORT_OE, PORT_OUT}), 32'h0000_F0A5);
		$display("test pin_level done");
	endtask
	// mux pin case: function, mux dir, open drain, peripheral drive, expectations
	task automatic mx(input logic [5:0] f, input logic [2:0] md, od, input logic [3:0] pv,
		input logic [2:0] eoe, eout, input logic [3:0] ein);
		{UART1_TX_PIN, TWOWIRE_CLOCK_PIN_OUT, TWOWIRE_DATA_PIN_OUT, UART0_CLOCK_PIN_OUT} <= pv;
		wr(8'h14, 32'(f), 2'b00);
		wr(8'h0C, 32'(md), 2'b00);
		wr(8'h10, 32'(od), 2'b00);
		repeat (3) @(posedge CORE_CLK);
		chk(32'({MUX_OE, MUX_OUT & MUX_OE}), 32'({eoe, eout}));
		chk(32'({UART0_RX_PIN, UART0_CLOCK_PIN_IN, TWOWIRE_DATA_PIN_IN, TWOWIRE_CLOCK_PIN_IN}),
			32'(ein));
	endtask
	task automatic t_mux;
		wr(8'h00, 32'h0000_000A, 2'b00);
		mx(6'h00, 3'h7, 3'h0, 4'h0, 3'h7, 3'h5, 4'hF);
		mx(6'h00, 3'h0, 3'h0, 4'hF, 3'h0, 3'h0, 4'hF);
		mx(6'h02, 3'h0, 3'h0, 4'h8, 3'h1, 3'h1, 4'hF);
		mx(6'h1B, 3'h0, 3'h0, 4'h0, 3'h3, 3'h0, 4'hC);
		mx(6'h18, 3'h7, 3'h0, 4'h0, 3'h5, 3'h5, 4'hB);
		mx(6'h08, 3'h0, 3'h0, 4'h1, 3'h2, 3'h2, 4'hF);
		mx(6'h20, 3'h0, 3'h0, 4'h0, 3'h2, 3'h0, 4'hF);
		mx(6'h04, 3'h7, 3'h0, 4'h0, 3'h3, 3'h1, 4'h7);
		mx(6'h08, 3'h7, 3'h7, 4'h1, 3'h0, 3'h0, 4'hF);
		mx(6'h02, 3'h0, 3'h7, 4'h0, 3'h1, 3'h0, 4'hF);
		$display("test mux_pins done");
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// main sequence, with a second reset in mid-run
	initial begin
		{S_AWADDR, S_AWVALID, S_WDATA, S_WVALID, S_ARADDR, S_ARVALID} <= '0;
		{UART1_TX_PIN, TWOWIRE_CLOCK_PIN_OUT, TWOWIRE_DATA_PIN_OUT, UART0_CLOCK_PIN_OUT} <= '0;
		{S_WSTRB, S_BREADY, S_RREADY, drv_val} <= {4'hF, 2'b11, 8'h5A};
		hold_reset;
		t_reset;
		t_level;
		t_mux;
		hold_reset;
		t_reset;
		results;
	end
endmodule
